// ==== verilog/clock_source_select_regs.vh ====
// Constants for the system clock source selection block
// Functional notes
// - Startup source from three-bit configuration field
// - Decode configuration field into eight clock modes
// - Software selects system clock at run time
// - Run-time select reaches secondary, internal or configured source
// - Internal block offers fast, medium, slow sources
// - Crystal modes count 1024 cycles after reset/wake
// - Stall execution during count unless monitor/two-speed
// - External clock modes skip the start-up count
// - Static on external clock; stopping keeps state
// - PLL on when either enable; config overrides
// - Monitor detects external failure, falls back internal
// - Secondary oscillator selectable as system clock
// - Secondary pin is I/O or clock output
// - Crystal modes use pin; else bit selects
// - Frequency select resets to 0111 (500 kHz)
`ifndef CLOCK_SOURCE_SELECT_REGS_VH
`define CLOCK_SOURCE_SELECT_REGS_VH
`define MODE_EXT_HIGH 3'h7
`define MODE_EXT_MED 3'h6
`define MODE_EXT_LOW 3'h5
`define MODE_INTERNAL 3'h4
`define MODE_RC 3'h3
`define MODE_XTAL_HIGH 3'h2
`define MODE_XTAL_MED 3'h1
`define MODE_XTAL_LOW 3'h0
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_IRQ_STATUS 4'h2
`define ADDR_IRQ_MASK 4'h3
`define CTRL_SCS_LSB 0
`define CTRL_FREQ_LSB 3
`define CTRL_PLL_BIT 7
`define FREQ_RESET 4'h7
`define SCS_CONFIG 2'h0
`define SCS_SECONDARY 2'h1
`define STARTUP_CYCLES 11'h400
`define FAIL_TIMEOUT 8'hc8
`define IRQ_FAIL_BIT 0
`define IRQ_READY_BIT 1
`define IRQ_SWITCH_BIT 2
`endif

// ==== verilog/glitchless_clock_gate.v ====
// Per-source enable handshake for a glitch-free clock multiplexer
`timescale 1ns/100ps
module glitchless_clock_gate (
    input wire i_clk_sys,   // System clock
    input wire i_reset,     // Synchronous reset, high
    input wire i_ce,        // Clock enable
    input wire i_want,      // This source requested
    input wire i_others_off,// All other sources released
    input wire i_src_fall,  // Falling edge seen on this source
    output reg o_on         // Source gated through
);
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_on <= 1'b0;
        end else if (i_ce && i_src_fall) begin
            // Change only while the source is low so no pulse is cut
            if (!i_want) begin
                o_on <= 1'b0;
            end else if (i_others_off) begin
                o_on <= 1'b1;
            end
        end
    end
endmodule

// ==== verilog/system_clock_source_select.v ====
// Oscillator mode decode, start-up timer, PLL, fail-safe and clock mux
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "clock_source_select_regs.vh"
module system_clock_source_select (
    input wire i_clk_sys,          // System clock, 20 MHz
    input wire i_reset,            // Synchronous reset, high
    input wire i_ce,               // Clock enable, freezes state when low
    input wire [2:0] i_osc_config, // Oscillator configuration field
    input wire i_config_pll_enable,// Configuration PLL enable
    input wire i_clock_output_enable, // Config bit, 0 gives clock out
    input wire i_fail_safe_enable, // Fail-safe monitor enable
    input wire i_two_speed_enable, // Two-speed start-up enable
    input wire i_powerup_delay_done, // Power-up timer expired
    input wire i_wake,             // Wake from sleep pulse
    input wire i_primary_osc_input,// Primary oscillator pin
    input wire i_secondary_osc,    // Secondary oscillator clock
    input wire i_internal_fast_source,   // 16 MHz internal
    input wire i_internal_medium_source, // 500 kHz internal
    input wire i_internal_slow_source,   // 31 kHz internal
    input wire [3:0] i_addr,       // Register address
    input wire [7:0] i_wdata,      // Register write data
    input wire i_wr,               // Write strobe
    input wire i_rd,               // Read strobe
    output reg [7:0] o_rdata,      // Read data
    output wire o_irq,             // Interrupt, high level
    output reg o_sys_clk,          // Selected system clock
    output wire o_pll_enable,      // 4x PLL enable
    output wire o_cpu_hold,        // Hold program counter
    output wire o_secondary_pin_osc,  // Pin used by oscillator
    output wire o_secondary_pin_clkout, // Pin drives clock output
    output wire o_clkout_oe,       // Pin output enable for clock out
    output reg [2:0] o_mode        // Decoded active mode
);
    function is_crystal;
        input [2:0] m;
        begin
            is_crystal = (m == `MODE_XTAL_HIGH) || (m == `MODE_XTAL_MED) ||
                (m == `MODE_XTAL_LOW);
        end
    endfunction
    function is_external;
        input [2:0] m;
        begin
            is_external = (m != `MODE_INTERNAL);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, change when stages two and three agree
    reg [2:0] prim_sync_reg;
    reg [2:0] sec_sync_reg;
    reg [2:0] fast_sync_reg;
    reg [2:0] med_sync_reg;
    reg [2:0] slow_sync_reg;
    reg prim_reg;
    reg sec_reg;
    reg fast_reg;
    reg med_reg;
    reg slow_reg;
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            prim_sync_reg <= 3'h0;
            sec_sync_reg <= 3'h0;
            fast_sync_reg <= 3'h0;
            med_sync_reg <= 3'h0;
            slow_sync_reg <= 3'h0;
            prim_reg <= 1'b0;
            sec_reg <= 1'b0;
            fast_reg <= 1'b0;
            med_reg <= 1'b0;
            slow_reg <= 1'b0;
        end else if (i_ce) begin
            prim_sync_reg <= {prim_sync_reg[1:0], i_primary_osc_input};
            sec_sync_reg <= {sec_sync_reg[1:0], i_secondary_osc};
            fast_sync_reg <= {fast_sync_reg[1:0], i_internal_fast_source};
            med_sync_reg <= {med_sync_reg[1:0], i_internal_medium_source};
            slow_sync_reg <= {slow_sync_reg[1:0], i_internal_slow_source};
            if (prim_sync_reg[1] == prim_sync_reg[2]) prim_reg <= prim_sync_reg[2];
            if (sec_sync_reg[1] == sec_sync_reg[2]) sec_reg <= sec_sync_reg[2];
            if (fast_sync_reg[1] == fast_sync_reg[2]) fast_reg <= fast_sync_reg[2];
            if (med_sync_reg[1] == med_sync_reg[2]) med_reg <= med_sync_reg[2];
            if (slow_sync_reg[1] == slow_sync_reg[2]) slow_reg <= slow_sync_reg[2];
        end
    end
    wire prim_fall = i_ce && prim_reg && (prim_sync_reg[1] == prim_sync_reg[2]) &&
        !prim_sync_reg[2];
    wire sec_fall = i_ce && sec_reg && (sec_sync_reg[1] == sec_sync_reg[2]) &&
        !sec_sync_reg[2];
    wire prim_rise = i_ce && !prim_reg && (prim_sync_reg[1] == prim_sync_reg[2]) &&
        prim_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0] control_reg;
    reg [2:0] irq_status_reg;
    reg [2:0] irq_mask_reg;
    reg [2:0] config_mode_reg;
    reg fail_reg;
    reg startup_done_reg;
    wire [1:0] scs = control_reg[`CTRL_SCS_LSB+1:`CTRL_SCS_LSB];
    wire [3:0] freq_sel = control_reg[`CTRL_FREQ_LSB+3:`CTRL_FREQ_LSB];
    wire [2:0] irq_events;
    wire [7:0] status_word = {3'h0, o_cpu_hold, startup_done_reg, fail_reg,
        o_pll_enable, 1'b0};
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            control_reg <= {1'b0, `FREQ_RESET, 3'h0};
            irq_mask_reg <= 3'h0;
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            if (i_wr && i_addr == `ADDR_CONTROL) control_reg <= i_wdata;
            if (i_wr && i_addr == `ADDR_IRQ_MASK) irq_mask_reg <= i_wdata[2:0];
            if (i_rd) begin
                case (i_addr)
                    `ADDR_CONTROL: o_rdata <= control_reg;
                    `ADDR_STATUS: o_rdata <= status_word;
                    `ADDR_IRQ_STATUS: o_rdata <= {5'h00, irq_status_reg};
                    `ADDR_IRQ_MASK: o_rdata <= {5'h00, irq_mask_reg};
                    default: o_rdata <= 8'h00;
                endcase
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end
    // Set wins over write-one-to-clear
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            irq_status_reg <= 3'h0;
        end else if (i_ce) begin
            irq_status_reg <= (irq_status_reg &
                ~((i_wr && i_addr == `ADDR_IRQ_STATUS) ? i_wdata[2:0] : 3'h0)) |
                irq_events;
        end
    end
    assign o_irq = |(irq_status_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Mode reloaded from the configuration field every enabled cycle after reset release
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            config_mode_reg <= `MODE_INTERNAL;
        end else if (i_ce) begin
            config_mode_reg <= i_osc_config;
        end
    end
    always @* begin
        o_mode = config_mode_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start-up timer counting primary oscillator cycles
    localparam ST_WAIT = 2'h0;
    localparam ST_COUNT = 2'h1;
    localparam ST_DONE = 2'h2;
    reg [1:0] st_reg;
    reg [10:0] st_count_reg;
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_reg <= ST_WAIT;
            st_count_reg <= 11'h000;
            startup_done_reg <= 1'b0;
        end else if (i_ce) begin
            case (st_reg)
                ST_WAIT: begin
                    st_count_reg <= 11'h000;
                    // Live field: the captured mode still holds its reset value here
                    if (!is_crystal(i_osc_config)) begin
                        st_reg <= ST_DONE;
                        startup_done_reg <= 1'b1;
                    end else if (i_powerup_delay_done) begin
                        st_reg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (prim_rise) begin
                        st_count_reg <= st_count_reg + 11'h001;
                        if (st_count_reg == `STARTUP_CYCLES - 11'h001) begin
                            st_reg <= ST_DONE;
                            startup_done_reg <= 1'b1;
                        end
                    end
                end
                ST_DONE: begin
                    if (i_wake && is_crystal(config_mode_reg)) begin
                        st_reg <= ST_COUNT;
                        st_count_reg <= 11'h000;
                        startup_done_reg <= 1'b0;
                    end
                end
                default: st_reg <= ST_WAIT;
            endcase
        end
    end
    assign o_cpu_hold = !startup_done_reg && !(i_fail_safe_enable || i_two_speed_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Fail-safe monitor: external clock with no edge for a timeout
    reg [7:0] fail_count_reg;
    reg [1:0] scs_prev_reg;
    wire ext_active = is_external(config_mode_reg) && (scs == `SCS_CONFIG);
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            fail_count_reg <= 8'h00;
            fail_reg <= 1'b0;
            scs_prev_reg <= 2'h0;
        end else if (i_ce) begin
            scs_prev_reg <= scs;
            if (!i_fail_safe_enable || !ext_active || prim_rise || prim_fall) begin
                fail_count_reg <= 8'h00;
            end else if (fail_count_reg != `FAIL_TIMEOUT) begin
                fail_count_reg <= fail_count_reg + 8'h01;
            end
            if (fail_count_reg == `FAIL_TIMEOUT) begin
                fail_reg <= 1'b1;
            end else if (scs != scs_prev_reg) begin
                fail_reg <= 1'b0;
            end
        end
    end
    wire fail_set = i_ce && !fail_reg && (fail_count_reg == `FAIL_TIMEOUT);
    wire ready_set = i_ce && !startup_done_reg && (st_reg == ST_COUNT) && prim_rise &&
        (st_count_reg == `STARTUP_CYCLES - 11'h001);
    wire switch_set = i_ce && (scs != scs_prev_reg);
    assign irq_events = {switch_set, ready_set, fail_set};

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and internal frequency choice
    reg int_clk;
    always @* begin
        if (freq_sel == 4'h0) begin
            int_clk = slow_reg;
        end else if (freq_sel[3]) begin
            int_clk = fast_reg;
        end else begin
            int_clk = med_reg;
        end
    end
    wire use_secondary = (scs == `SCS_SECONDARY) && !fail_reg;
    wire use_primary = (scs == `SCS_CONFIG) && ext_active && !fail_reg &&
        (startup_done_reg || !is_crystal(config_mode_reg));
    wire use_internal = !use_secondary && !use_primary;
    wire int_fall = i_ce && !int_clk;
    wire on_prim;
    wire on_sec;
    wire on_int;
    glitchless_clock_gate gate_prim (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_want(use_primary),
        .i_others_off(!on_sec && !on_int),
        .i_src_fall(prim_fall || !prim_reg),
        .o_on(on_prim)
    );
    glitchless_clock_gate gate_sec (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_want(use_secondary),
        .i_others_off(!on_prim && !on_int),
        .i_src_fall(sec_fall || !sec_reg),
        .o_on(on_sec)
    );
    glitchless_clock_gate gate_int (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_want(use_internal),
        .i_others_off(!on_prim && !on_sec),
        .i_src_fall(int_fall),
        .o_on(on_int)
    );
    // Clock output stops with the source, keeping all state (static design)
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_sys_clk <= 1'b0;
        end else if (i_ce) begin
            o_sys_clk <= (on_prim & prim_reg) | (on_sec & sec_reg) |
                (on_int & int_clk);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PLL enable and secondary pin function
    assign o_pll_enable = i_config_pll_enable | control_reg[`CTRL_PLL_BIT];
    assign o_secondary_pin_osc = is_crystal(config_mode_reg);
    assign o_secondary_pin_clkout = !is_crystal(config_mode_reg) &&
        !i_clock_output_enable;
    assign o_clkout_oe = o_secondary_pin_clkout;
endmodule

// ==== tb/osc_partner.sv ====
// Far-side clock sources: primary oscillator, secondary crystal, internal block
`timescale 1ns/100ps
module osc_partner (
    input wire i_run, // Primary oscillator running
    output logic o_primary, // Primary oscillator pin
    output logic o_secondary, // Secondary 32.768 kHz crystal
    output logic o_fast, // 16 MHz internal
    output logic o_medium, // 500 kHz internal
    output logic o_slow // 31 kHz internal
);
    initial begin
        {o_primary, o_secondary, o_fast, o_medium, o_slow} = 5'h00;
    end
    // A stopped oscillator rests low, as a dead crystal would
    always #125 o_primary = i_run ? ~o_primary : 1'b0;
    always #15259 o_secondary = ~o_secondary;
    always #31.25 o_fast = ~o_fast;
    always #1000 o_medium = ~o_medium;
    always #16129 o_slow = ~o_slow;
endmodule

// ==== tb/system_clock_source_select_chk.sv ====
// Port assertions for the clock source selection block
`timescale 1ns/100ps
module system_clock_source_select_chk (
    input wire i_clk_sys, // System clock
    input wire i_reset, // Synchronous reset
    input wire i_ce, // Clock enable
    input wire [2:0] i_osc_config, // Mode field
    input wire i_config_pll_enable, // Config PLL enable
    input wire i_clock_output_enable, // Clock out select
    input wire i_fail_safe_enable, // Monitor enable
    input wire i_two_speed_enable, // Two-speed enable
    input wire i_wr, // Write strobe
    input wire i_rd, // Read strobe
    input wire [7:0] o_rdata, // Read data
    input wire o_irq, // Interrupt
    input wire o_pll_enable, // PLL enable
    input wire o_cpu_hold, // Execution hold
    input wire o_secondary_pin_osc, // Pin in oscillator use
    input wire o_secondary_pin_clkout, // Pin gives clock out
    input wire o_clkout_oe, // Clock out enable
    input wire [2:0] o_mode // Active mode
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    AST_PLL_CONFIG: assert property (i_config_pll_enable |-> o_pll_enable)
        else $error("pll off while config enable set");
    AST_HOLD_BYPASS: assert property (
        (i_fail_safe_enable || i_two_speed_enable) |-> !o_cpu_hold)
        else $error("hold with monitor or two-speed on");
    AST_HOLD_NONXTAL: assert property ((o_mode >= 3'h3) [*3] |-> !o_cpu_hold)
        else $error("hold in a mode without start-up count");
    AST_MODE_CAPTURE: assert property (
        $past(i_ce) && !$past(i_reset) |-> o_mode == $past(i_osc_config))
        else $error("mode not taken from config field");
    AST_PIN_OSC: assert property (o_secondary_pin_osc == (o_mode < 3'h3))
        else $error("pin oscillator use wrong for mode");
    AST_PIN_CLKOUT: assert property (
        o_secondary_pin_clkout == (o_mode >= 3'h3 && !i_clock_output_enable))
        else $error("pin clock out wrong");
    AST_CLKOUT_OE: assert property (o_clkout_oe == o_secondary_pin_clkout)
        else $error("clock out enable differs from pin use");
    AST_IRQ_STICKY: assert property (!$past(i_wr) && $past(o_irq) |-> o_irq)
        else $error("interrupt dropped without a write");
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule
bind system_clock_source_select system_clock_source_select_chk chk (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(i_ce), .i_osc_config(i_osc_config),
    .i_config_pll_enable(i_config_pll_enable), .i_clock_output_enable(i_clock_output_enable),
    .i_fail_safe_enable(i_fail_safe_enable), .i_two_speed_enable(i_two_speed_enable),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_pll_enable(o_pll_enable),
    .o_cpu_hold(o_cpu_hold), .o_secondary_pin_osc(o_secondary_pin_osc),
    .o_secondary_pin_clkout(o_secondary_pin_clkout), .o_clkout_oe(o_clkout_oe), .o_mode(o_mode));

// ==== tb/testbench.sv ====
// Self-checking bench for the clock source selection block
`timescale 1ns/100ps
module testbench;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic [2:0] i_osc_config = 3'h4;
    logic i_config_pll_enable = 1'b0;
    logic i_clock_output_enable = 1'b0;
    logic i_fail_safe_enable = 1'b0;
    logic i_two_speed_enable = 1'b0;
    logic i_wake = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic run = 1'b1;
    logic ce = 1'b1;
    logic [7:0] d;
    logic [2:0] cfg;
    wire pri, sec, fst, med, slw, o_irq, o_sys_clk, o_pll_enable, o_cpu_hold;
    wire o_secondary_pin_osc, o_secondary_pin_clkout, o_clkout_oe;
    wire [7:0] o_rdata;
    wire [2:0] o_mode;
    integer miscompares = 0;
    integer checked = 0;
    integer seed = 32'ha537;
    integer cycles = 0;
    integer i, n, e;
    integer per [4] = '{30518, 2000, 32258, 250};
    logic [7:0] sel [4] = '{8'h39, 8'h3a, 8'h03, 8'h38};
    osc_partner far (.i_run(run), .o_primary(pri), .o_secondary(sec), .o_fast(fst),
        .o_medium(med), .o_slow(slw));
    system_clock_source_select uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(ce),
        .i_osc_config(i_osc_config), .i_config_pll_enable(i_config_pll_enable),
        .i_clock_output_enable(i_clock_output_enable), .i_fail_safe_enable(i_fail_safe_enable),
        .i_two_speed_enable(i_two_speed_enable), .i_powerup_delay_done(1'b1), .i_wake(i_wake),
        .i_primary_osc_input(pri), .i_secondary_osc(sec), .i_internal_fast_source(fst),
        .i_internal_medium_source(med), .i_internal_slow_source(slw), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_sys_clk(o_sys_clk), .o_pll_enable(o_pll_enable), .o_cpu_hold(o_cpu_hold),
        .o_secondary_pin_osc(o_secondary_pin_osc),
        .o_secondary_pin_clkout(o_secondary_pin_clkout), .o_clkout_oe(o_clkout_oe),
        .o_mode(o_mode));
    initial begin
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares = miscompares + 1;
            close_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    function automatic logic xtal(input logic [2:0] m);
        xtal = m < 3'h3;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        @(negedge i_clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(negedge i_clk_sys);
        v = o_rdata;
    endtask
    task automatic do_reset(input logic [2:0] m);
        @(posedge i_clk_sys);
        i_osc_config <= m;
        i_reset <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask
    // Counts cycles while the named condition holds, bounded
    task automatic wait_while(input logic hold, output integer c);
        c = 0;
        while ((hold ? o_cpu_hold === 1'b1 : o_irq !== 1'b1) && c < 6000) begin
            @(negedge i_clk_sys);
            c = c + 1;
        end
    endtask
    task automatic count_toggles(output integer t);
        logic p;
        p = o_sys_clk;
        t = 0;
        repeat (2441) begin
            @(negedge i_clk_sys);
            if (o_sys_clk !== p) t = t + 1;
            p = o_sys_clk;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(3'h4);
        rd(4'h0, d);
        chk(d, 8'h38);
        wr(4'h5, 8'hff);
        rd(4'h5, d);
        chk(d, 8'h00);
        // All mode codes, then random codes and option bits
        for (i = 0; i < 16; i = i + 1) begin
            d = $random(seed);
            cfg = (i < 8) ? i[2:0] : d[2:0];
            i_clock_output_enable <= d[3];
            i_config_pll_enable <= d[4];
            do_reset(cfg);
            chk({5'h00, o_mode}, {5'h00, cfg});
            chk1(o_secondary_pin_osc, xtal(cfg));
            chk1(o_clkout_oe, !xtal(cfg) && !d[3]);
            chk1(o_cpu_hold, xtal(cfg));
            chk1(o_pll_enable, d[4]);
        end
        i_config_pll_enable <= 1'b0;
        wr(4'h0, 8'hb8);
        rd(4'h1, d);
        chk1(d[1], 1'b1);
        wr(4'h0, 8'h38);
        chk1(o_pll_enable, 1'b0);
        // A write while the clock enable is low must leave all state alone
        @(posedge i_clk_sys);
        ce <= 1'b0;
        wr(4'h0, 8'h81);
        @(posedge i_clk_sys);
        ce <= 1'b1;
        rd(4'h0, d);
        chk(d, 8'h38);
        // Start-up count of 1024 primary cycles, 5 system cycles each
        do_reset(3'h1);
        wait_while(1'b1, n);
        chk1(n >= 5100 && n <= 5140, 1'b1);
        rd(4'h2, d);
        chk1(d[1], 1'b1);
        wr(4'h2, 8'h02);
        rd(4'h2, d);
        chk1(d[1], 1'b0);
        @(posedge i_clk_sys);
        i_wake <= 1'b1;
        @(posedge i_clk_sys);
        i_wake <= 1'b0;
        @(negedge i_clk_sys);
        chk1(o_cpu_hold, 1'b1);
        wait_while(1'b1, n);
        chk1(n >= 5095 && n <= 5140, 1'b1);
        // Monitor trips 200 cycles after the primary stops
        i_fail_safe_enable <= 1'b1;
        do_reset(3'h2);
        wr(4'h3, 8'h02);
        wait_while(1'b0, n);
        chk1(n < 6000, 1'b1);
        wr(4'h3, 8'h01);
        chk1(o_irq, 1'b0);
        run <= 1'b0;
        wait_while(1'b0, n);
        chk1(n >= 190 && n <= 215, 1'b1);
        rd(4'h1, d);
        chk1(d[2], 1'b1);
        wr(4'h3, 8'h00);
        chk1(o_irq, 1'b0);
        run <= 1'b1;
        i_fail_safe_enable <= 1'b0;
        wr(4'h2, 8'h07);
        wr(4'h3, 8'h04);
        // Secondary, internal medium, internal slow, then configured source
        for (i = 0; i < 4; i = i + 1) begin
            wr(4'h2, 8'h04);
            wr(4'h0, sel[i]);
            wait_while(1'b0, n);
            chk1(n < 6000, 1'b1);
            repeat (1300) @(negedge i_clk_sys);
            count_toggles(n);
            e = 244100 / per[i];
            chk1(n >= e - e / 32 - 2 && n <= e + e / 32 + 2, 1'b1);
        end
        close_out;
    end
endmodule
